// ---- src/asr_defines.svh ----
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Local clock rate in MHz (5 ns period)
`define ASR_MCLK_MHZ 200

// Result width and link pin positions in the sampled pin vector
`define ASR_RES_BITS 16
`define ASR_PIN_SCK 0
`define ASR_PIN_CS_N 1
`define ASR_PIN_RC_N 2
`define ASR_PIN_TAG 3
`define ASR_PIN_SEL 4
`define ASR_PIN_COUNT 5

// Synchroniser depth on every pin input
`define ASR_SYNC_STAGES 2

// Pulse numbers of the readout frame
`define ASR_PULSE_SYNC 5'h01
`define ASR_PULSE_MSB 5'h02
`define ASR_PULSE_LSB 5'h11
`define ASR_PULSE_TAG 5'h12
`define ASR_PULSE_END 5'h13

// Times in ns as printed
`define ASR_T_BUSY_MAX_NS 83
`define ASR_T_RC_SCK_MIN_NS 15
`define ASR_T_SYNC_NS 50
`define ASR_T_DATA_NS 40
`define ASR_T_CONV_NS 5000

// Times in cycles: longest rounds down, least rounds up
`define ASR_BUSY_MAX_CYC ((`ASR_T_BUSY_MAX_NS * `ASR_MCLK_MHZ) / 1000)
`define ASR_RC_SCK_MIN_CYC ((`ASR_T_RC_SCK_MIN_NS * `ASR_MCLK_MHZ + 999) / 1000)
`define ASR_SYNC_CYC ((`ASR_T_SYNC_NS * `ASR_MCLK_MHZ) / 1000)
`define ASR_DATA_CYC ((`ASR_T_DATA_NS * `ASR_MCLK_MHZ) / 1000)
`define ASR_CONV_CYC ((`ASR_T_CONV_NS * `ASR_MCLK_MHZ) / 1000)

// Host shift clock half period; 8 cycles gives 12.5 MHz, above the 10 MHz floor
`define ASR_HOST_HALF_CYC 8
`define ASR_SCK_MIN_MHZ 10

`endif

// ---- src/asr_pkg.sv ----
package asr_pkg;

  // Converter state of the device end
  typedef enum logic [1:0] {
    ASR_DEV_IDLE = 2'b01,
    ASR_DEV_CONV = 2'b10
  } asr_dev_state_e;

  // Sequencer state of the host end
  typedef enum logic [3:0] {
    ASR_HST_IDLE = 4'b0001,
    ASR_HST_START = 4'b0010,
    ASR_HST_READ = 4'b0100,
    ASR_HST_DONE = 4'b1000
  } asr_hst_state_e;

endpackage

// ---- src/asr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Pins between converter and host controller
interface asr_link_if;
  logic serial_shift_clock; // Continuous readout clock from host
  logic cs_n; // Chip select, active low
  logic rc_n; // Read high, convert low
  logic tag; // Tag bit echoed after the result
  logic clock_source_select; // High selects external shift clock
  logic busy_n; // Low while converting
  logic data; // Serial sync, result and tag

  // Converter end
  modport device (
    input serial_shift_clock, cs_n, rc_n, tag, clock_source_select,
    output busy_n, data
  );

  // Host controller end
  modport host (
    output serial_shift_clock, cs_n, rc_n, tag, clock_source_select,
    input busy_n, data
  );
endinterface

`default_nettype wire

// ---- src/asr_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "asr_defines.svh"
// Function
// [RULE1] Source select high enables external clock readout
// [RULE2] Sync armed by clock edge, select high/both low
// [RULE3] Host toggles chip select, never tied low
// [RULE4] Convert low with select low starts, arms sync
// [RULE5] Busy falls within 83 ns of convert
// [RULE6] Host waits over 15 ns before pulse one
// [RULE7] Sync appears 50 ns after pulse one
// [RULE8] MSB 40 ns after pulse two
// [RULE9] LSB held through pulse seventeen fall
// [RULE10] Tag from pulse two sent after eighteen
// [RULE11] Previous result shifted during current conversion
// [RULE12] Host reads within first half of busy
// [RULE13] Host shift clock at least 10 MHz
// [RULE14] Host keeps select low, convert high reading
// [RULE15] Sixteen bits MSB first, pulses two-seventeen
module asr_device
  import asr_pkg::*;
#(
  parameter int WIDTH = `ASR_RES_BITS,
  parameter int CONV_CYC = `ASR_CONV_CYC
)(
  // Clock, reset and enable
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Link to the host controller
  asr_link_if.device lnk,
  // Converter core side
  input wire logic [WIDTH-1:0] i_sample,
  output logic o_converting,
  output logic [WIDTH-1:0] o_result
);

  localparam int CW = $clog2(CONV_CYC + 1);

  // Two-stage pin synchroniser
  logic [`ASR_PIN_COUNT-1:0] pin_raw; // Pins as they arrive
  logic [`ASR_PIN_COUNT-1:0] pin_s1; // First stage, read only by pin_s2
  logic [`ASR_PIN_COUNT-1:0] pin_s2; // Settled pins
  logic sck_prev; // Shift clock one cycle back
  logic rc_prev; // Convert line one cycle back

  // Decoded pin levels and events
  logic sck;
  logic cs_n;
  logic rc_n;
  logic tag_in;
  logic ext_mode;
  logic sck_rise;
  logic sck_edge;
  logic rc_fall;
  logic start_req;

  // Converter state
  asr_dev_state_e state; // Idle or converting
  logic [CW-1:0] conv_cnt; // Cycles left in conversion
  logic busy_n; // Busy pin register
  logic [WIDTH-1:0] result; // Last finished result

  // Readout state
  logic armed; // Sync generation enabled
  logic [4:0] pulse; // Rising edges counted in frame
  logic [4:0] next_pulse; // Pulse number of this edge
  logic frame_rise; // Counted edge of a read frame
  logic [WIDTH-1:0] shadow; // Previous result being shifted
  logic tag_held; // Tag sampled at pulse two
  logic sched; // A new output bit is due
  logic sched_val; // Value of that bit
  logic [3:0] sched_dly; // Its delay in cycles
  logic pend_v; // Delayed bit waiting
  logic pend; // Delayed bit value
  logic [3:0] dly; // Cycles left before driving
  logic data_q; // Data pin register

  // Gather the pins into one vector
  assign pin_raw[`ASR_PIN_SCK] = lnk.serial_shift_clock;
  assign pin_raw[`ASR_PIN_CS_N] = lnk.cs_n;
  assign pin_raw[`ASR_PIN_RC_N] = lnk.rc_n;
  assign pin_raw[`ASR_PIN_TAG] = lnk.tag;
  assign pin_raw[`ASR_PIN_SEL] = lnk.clock_source_select;

  // Synchronise all pins and keep last levels
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_s1 <= 5'h06;
      pin_s2 <= 5'h06;
      sck_prev <= 1'b0;
      rc_prev <= 1'b1;
    end
    else if (i_ce)
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      sck_prev <= pin_s2[`ASR_PIN_SCK];
      rc_prev <= pin_s2[`ASR_PIN_RC_N];
    end
  end

  // Settled levels and detected edges
  assign sck = pin_s2[`ASR_PIN_SCK];
  assign cs_n = pin_s2[`ASR_PIN_CS_N];
  assign rc_n = pin_s2[`ASR_PIN_RC_N];
  assign tag_in = pin_s2[`ASR_PIN_TAG];
  assign ext_mode = pin_s2[`ASR_PIN_SEL]; // RULE1
  assign sck_rise = sck & ~sck_prev;
  assign sck_edge = sck ^ sck_prev;
  assign rc_fall = rc_prev & ~rc_n;

  // Convert request: convert falls while selected and idle
  assign start_req = rc_fall & ~cs_n & (state == ASR_DEV_IDLE); // RULE4

  // Conversion sequencer and busy pin
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ASR_DEV_IDLE;
      conv_cnt <= '0;
      busy_n <= 1'b1;
      result <= '0;
      o_converting <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (state)
        ASR_DEV_IDLE:
        begin
          // Busy falls one cycle after the settled edge
          if (start_req)
          begin
            state <= ASR_DEV_CONV;
            busy_n <= 1'b0; // RULE5
            o_converting <= 1'b1;
            conv_cnt <= CW'(CONV_CYC - 1);
          end
        end
        ASR_DEV_CONV:
        begin
          // Finish: store new result and release busy
          if (conv_cnt == '0)
          begin
            state <= ASR_DEV_IDLE;
            busy_n <= 1'b1;
            result <= i_sample;
            o_converting <= 1'b0;
          end
          else
          begin
            conv_cnt <= conv_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // A counted rising edge of an active read frame
  assign frame_rise = sck_rise & armed & ~cs_n & rc_n & ext_mode; // RULE14
  assign next_pulse = pulse + 5'h01;

  // Frame pulse counter and sync arming
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      armed <= 1'b0;
      pulse <= 5'h00;
    end
    else if (i_ce)
    begin
      if (!ext_mode)
      begin
        // Internal clock mode: no external readout
        armed <= 1'b0;
        pulse <= 5'h00;
      end
      else if (sck_edge && (cs_n || !rc_n))
      begin
        // Transition while deselected or converting arms sync
        armed <= 1'b1; // RULE2
        pulse <= 5'h00; // RULE4
      end
      else if (frame_rise)
      begin
        // Frame ends after the tag pulse
        if (next_pulse == `ASR_PULSE_END)
        begin
          armed <= 1'b0;
          pulse <= 5'h00;
        end
        else
        begin
          pulse <= next_pulse;
        end
      end
    end
  end

  // Bit due on this edge and its delay
  always_comb
  begin
    sched = frame_rise;
    sched_val = 1'b0;
    sched_dly = 4'(`ASR_DATA_CYC);
    if (next_pulse == `ASR_PULSE_SYNC)
    begin
      // Sync marker, later than data bits
      sched_val = 1'b1; // RULE7
      sched_dly = 4'(`ASR_SYNC_CYC); // RULE7
    end
    else if (next_pulse >= `ASR_PULSE_MSB && next_pulse <= `ASR_PULSE_LSB)
    begin
      // Result bits, most significant first
      sched_val = shadow[WIDTH-1]; // RULE8 RULE15
    end
    else if (next_pulse == `ASR_PULSE_TAG)
    begin
      // Tag echo follows the last bit
      sched_val = tag_held; // RULE10
    end
  end

  // Shadow register: loads old result at start, shifts per bit
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      shadow <= '0;
      tag_held <= 1'b0;
    end
    else if (i_ce)
    begin
      if (start_req)
      begin
        // Previous conversion stays readable during this one
        shadow <= result; // RULE11
      end
      else if (frame_rise && next_pulse >= `ASR_PULSE_MSB && next_pulse <= `ASR_PULSE_LSB)
      begin
        shadow <= {shadow[WIDTH-2:0], 1'b0}; // RULE15
      end
      // Tag sampled on the MSB edge
      if (frame_rise && next_pulse == `ASR_PULSE_MSB)
      begin
        tag_held <= tag_in; // RULE10
      end
    end
  end

  // Output delay line: a bit lands a fixed time after its edge
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend_v <= 1'b0;
      pend <= 1'b0;
      dly <= 4'h0;
      data_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (sched)
      begin
        // LSB stays on the pin until this new bit lands
        pend_v <= 1'b1; // RULE9
        pend <= sched_val;
        dly <= sched_dly - 4'h1;
      end
      else if (pend_v)
      begin
        if (dly == 4'h0)
        begin
          data_q <= pend;
          pend_v <= 1'b0;
        end
        else
        begin
          dly <= dly - 4'h1;
        end
      end
      else if (cs_n)
      begin
        // Deselected: data pin rests low
        data_q <= 1'b0;
      end
    end
  end

  // Pins and user outputs
  assign lnk.busy_n = busy_n;
  assign lnk.data = data_q;
  assign o_result = result;

endmodule

`default_nettype wire

// ---- src/asr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "asr_defines.svh"
module asr_host
  import asr_pkg::*;
#(
  parameter int WIDTH = `ASR_RES_BITS,
  parameter int HALF_CYC = `ASR_HOST_HALF_CYC
)(
  // Clock, reset and enable
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Link to the converter
  asr_link_if.host lnk,
  // User request side
  input wire logic i_start,
  input wire logic i_tag,
  // User answer side
  output logic o_valid,
  output logic [WIDTH-1:0] o_result,
  output logic o_tag,
  output logic o_sync_ok,
  output logic o_busy,
  output logic o_busy_err
);

  localparam int DW = $clog2(HALF_CYC);
  localparam int TW = 8;
  localparam logic [TW-1:0] BUSY_LIMIT = TW'(`ASR_BUSY_MAX_CYC + 2 * `ASR_SYNC_STAGES);

  // Shift clock divider
  logic [DW-1:0] div_cnt; // Cycles into the half period
  logic sck_q; // Shift clock pin register
  logic tick; // Clock toggles this cycle
  logic rise_now; // Rising edge this cycle
  logic fall_now; // Falling edge this cycle

  // Input synchronisers
  logic busy_s1; // First stage, read only by busy_s2
  logic busy_s2; // Settled busy, active low
  logic data_s1; // First stage, read only by data_s2
  logic data_s2; // Settled data

  // Sequencer
  asr_hst_state_e state; // Current step
  logic cs_n_q; // Chip select pin register
  logic rc_n_q; // Convert pin register
  logic tag_q; // Tag pin register
  logic sel_q; // Clock source pin register
  logic [TW-1:0] timer; // Wait for busy
  logic busy_seen; // Busy low observed
  logic edge_seen; // Pulse zero sent while converting
  logic [4:0] rcnt; // Rising edges in read
  logic [4:0] next_rcnt; // Number of this edge
  logic [WIDTH-1:0] shreg; // Bits collected

  assign tick = (div_cnt == DW'(HALF_CYC - 1));
  assign rise_now = tick & ~sck_q;
  assign fall_now = tick & sck_q;
  assign next_rcnt = rcnt + 5'h01;

  // Free-running shift clock, never stopped
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_cnt <= '0;
      sck_q <= 1'b0;
    end
    else if (i_ce)
    begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      if (tick)
      begin
        sck_q <= ~sck_q; // RULE13
      end
    end
  end

  // Two flip-flops on busy and data
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
    end
    else if (i_ce)
    begin
      busy_s1 <= lnk.busy_n;
      busy_s2 <= busy_s1;
      data_s1 <= lnk.data;
      data_s2 <= data_s1;
    end
  end

  // Conversion and readout sequencer
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ASR_HST_IDLE;
      cs_n_q <= 1'b1;
      rc_n_q <= 1'b1;
      tag_q <= 1'b0;
      sel_q <= 1'b1; // RULE1
      timer <= '0;
      busy_seen <= 1'b0;
      edge_seen <= 1'b0;
      rcnt <= 5'h00;
      shreg <= '0;
      o_valid <= 1'b0;
      o_result <= '0;
      o_tag <= 1'b0;
      o_sync_ok <= 1'b0;
      o_busy <= 1'b0;
      o_busy_err <= 1'b0;
    end
    else if (i_ce)
    begin
      o_valid <= 1'b0;
      o_busy <= ~busy_s2;
      unique case (state)
        ASR_HST_IDLE:
        begin
          // Deselected between frames
          cs_n_q <= 1'b1; // RULE3
          rc_n_q <= 1'b1;
          if (i_start && busy_s2)
          begin
            state <= ASR_HST_START;
            cs_n_q <= 1'b0; // RULE4
            rc_n_q <= 1'b0; // RULE4
            tag_q <= i_tag;
            timer <= '0;
            busy_seen <= 1'b0;
            edge_seen <= 1'b0;
            o_busy_err <= 1'b0;
          end
        end
        ASR_HST_START:
        begin
          timer <= timer + 1'b1;
          if (!busy_s2)
          begin
            busy_seen <= 1'b1;
          end
          if (tick)
          begin
            edge_seen <= 1'b1; // RULE4
          end
          if (busy_seen && edge_seen && fall_now)
          begin
            // Convert high on a fall: next rise a half period away
            rc_n_q <= 1'b1; // RULE6 RULE14
            rcnt <= 5'h00;
            state <= ASR_HST_READ; // RULE12
          end
          else if (!busy_seen && timer == BUSY_LIMIT)
          begin
            // Busy never fell: abandon
            o_busy_err <= 1'b1; // RULE5
            state <= ASR_HST_IDLE;
          end
        end
        ASR_HST_READ:
        begin
          // Each bit latched on the rise after its own pulse
          if (rise_now)
          begin
            rcnt <= next_rcnt;
            if (next_rcnt == `ASR_PULSE_MSB)
            begin
              o_sync_ok <= data_s2; // RULE7
            end
            else if (next_rcnt > `ASR_PULSE_MSB && next_rcnt <= `ASR_PULSE_TAG)
            begin
              shreg <= {shreg[WIDTH-2:0], data_s2}; // RULE8 RULE15
            end
            else if (next_rcnt == `ASR_PULSE_END)
            begin
              o_tag <= data_s2; // RULE10
              cs_n_q <= 1'b1; // RULE3
              state <= ASR_HST_DONE;
            end
          end
        end
        ASR_HST_DONE:
        begin
          // Hand the word over
          o_result <= shreg;
          o_valid <= 1'b1;
          state <= ASR_HST_IDLE;
        end
      endcase
    end
  end

  // Pin drive
  assign lnk.serial_shift_clock = sck_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.rc_n = rc_n_q;
  assign lnk.tag = tag_q;
  assign lnk.clock_source_select = sel_q;

endmodule

`default_nettype wire

// ---- sim/asr_check_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module asr_check (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Link pins
  input wire logic serial_shift_clock,
  input wire logic cs_n,
  input wire logic rc_n,
  input wire logic tag,
  input wire logic clock_source_select,
  input wire logic busy_n,
  input wire logic data
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  logic sck_q; // Shift clock one cycle back
  logic rise; // Shift clock rise seen now
  logic [3:0] half_cnt; // Cycles since last clock edge
  logic [4:0] rise_cnt; // Rises of this readout
  logic [10:0] sel_cnt; // Cycles with select low
  logic tag_q; // Tag level at pulse two

  assign rise = serial_shift_clock && !sck_q;

  // Clock history and edge spacing
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      sck_q <= 1'b0;
      half_cnt <= 4'h0;
    end
    else
    begin
      sck_q <= serial_shift_clock;
      half_cnt <= (serial_shift_clock != sck_q) ? 4'h0 : half_cnt + 4'h1;
    end

  // Pulse count, cleared while convert is low
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      rise_cnt <= 5'h0;
    else if (!rc_n)
      rise_cnt <= 5'h0;
    else if (rise && !cs_n && rise_cnt != 5'h1f)
      rise_cnt <= rise_cnt + 5'h1;

  // Select low time and tag capture
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      sel_cnt <= 11'h0;
      tag_q <= 1'b0;
    end
    else
    begin
      sel_cnt <= cs_n ? 11'h0 : sel_cnt + 11'h1;
      if (rise && !cs_n && rise_cnt == 5'h1)
        tag_q <= tag;
    end

  src_sel_high_a: assert property (clock_source_select)
    else $error("clock source select low");
  sel_bounded_a: assert property (sel_cnt < 11'd1000)
    else $error("chip select held low too long");
  start_sel_a: assert property ($fell(rc_n) |-> !cs_n)
    else $error("convert without chip select");
  busy_fast_a: assert property ($fell(rc_n) && busy_n |-> ##[1:15] !busy_n)
    else $error("busy did not fall in time");
  rc_gap_a: assert property ($rose(rc_n) |-> !serial_shift_clock [*4])
    else $error("pulse one too close to convert rise");
  sync_time_a: assert property (rise && !cs_n && rc_n && rise_cnt == 5'h0 |-> ##[8:14] $rose(data))
    else $error("sync pulse missing");
  bit_hold_a: assert property (rise && !cs_n && rise_cnt >= 5'h1 && rise_cnt <= 5'h11
    |=> $stable(data) [*4])
    else $error("data bit not held after rise");
  tag_echo_a: assert property (rise && !cs_n && rise_cnt == 5'h11 |-> ##15 (data == tag_q))
    else $error("tag echo wrong");
  sel_held_a: assert property (rise_cnt >= 5'h1 && rise_cnt <= 5'h11 |=> !cs_n && rc_n)
    else $error("select or convert moved in readout");
  sck_rate_a: assert property (half_cnt < 4'ha)
    else $error("shift clock too slow");

  // Main scenarios
  cover property (rise && !cs_n && rise_cnt == 5'h11);
  cover property ($fell(busy_n));
  cover property ($rose(busy_n));
endmodule
`default_nettype wire

// ---- sim/tb_adc_serial_read_during_conversion.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_read_during_conversion
  import asr_pkg::*;
;
  localparam int CONV = 800; // Short conversion, readout fits first half

  logic i_mclk = 1'b0; // Local clock
  logic i_arst_n = 1'b0; // Reset
  logic i_start = 1'b0; // Host request
  logic i_tag = 1'b0; // Host tag
  logic [15:0] i_sample = 16'h0; // Converter input
  logic o_valid, o_tag, o_sync_ok, o_busy, o_busy_err; // Host answers
  logic [15:0] o_result, dev_result, res_b; // Results
  logic dev_conv, conv_b; // Converting flags
  int err_count = 0; // Mismatches
  int checks = 0; // Comparisons
  logic sck_q = 1'b0; // Wire monitor clock history
  logic [4:0] wcnt = 5'h13; // Wire monitor pulse count
  logic [17:0] wbits = 18'h0; // Sync, word and tag off the wire

  asr_link_if lnk(); // Link between both ends
  asr_link_if lnk_b(); // Link driven by the bench

  asr_device #(.CONV_CYC(CONV)) u_asr_device (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_ce(1'b1), .lnk(lnk.device), .i_sample(i_sample), .o_converting(dev_conv),
    .o_result(dev_result));
  asr_host u_asr_host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .lnk(lnk.host), .i_start(i_start), .i_tag(i_tag), .o_valid(o_valid),
    .o_result(o_result), .o_tag(o_tag), .o_sync_ok(o_sync_ok), .o_busy(o_busy),
    .o_busy_err(o_busy_err));
  asr_device #(.CONV_CYC(CONV)) u_asr_device_2 (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_ce(1'b1), .lnk(lnk_b.device), .i_sample(i_sample), .o_converting(conv_b),
    .o_result(res_b));
  asr_check u_asr_check (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .serial_shift_clock(lnk.serial_shift_clock), .cs_n(lnk.cs_n), .rc_n(lnk.rc_n),
    .tag(lnk.tag), .clock_source_select(lnk.clock_source_select),
    .busy_n(lnk.busy_n), .data(lnk.data));

  // Clock
  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Wire monitor: data seen at rises two to nineteen
  always @(posedge i_mclk)
  begin
    sck_q <= lnk.serial_shift_clock;
    if (!lnk.rc_n)
      wcnt <= 5'h0;
    else if (lnk.serial_shift_clock && !sck_q && wcnt < 5'h13)
    begin
      wcnt <= wcnt + 5'h1;
      if (wcnt >= 5'h1)
        wbits <= {wbits[16:0], lnk.data};
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait on valid, host busy or bench-side busy
  task automatic wait_on(input int which, input logic val, output int n);
    logic s;
    for (n = 0; n <= 2000; n++)
    begin
      s = (which == 0) ? o_valid : (which == 1) ? o_busy : lnk_b.busy_n;
      if (s === val)
        return;
      @(negedge i_mclk);
    end
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    stop_test();
  endtask

  // One readout through the host, then wait for the conversion
  task automatic frame(input logic [15:0] smp, input logic tg, input logic [15:0] exp);
    int n;
    @(negedge i_mclk);
    i_sample = smp;
    i_tag = tg;
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    wait_on(0, 1'b1, n);
    check(o_result, exp);
    check(o_tag, tg);
    check(o_sync_ok, 1'b1);
    check(o_busy_err, 1'b0);
    check(dev_conv, 1'b1);
    check(n < CONV / 2, 1'b1);
    check(wbits[16:1], exp);
    check(wbits[17], 1'b1);
    check(wbits[0], tg);
    wait_on(1, 1'b0, n);
    repeat (4) @(negedge i_mclk);
    check(dev_result, smp);
    $display("frame of %h done", smp);
  endtask

  // One bench clock pulse on the second link, 40 ns low then 40 ns high
  task automatic pulse_b();
    repeat (8) @(negedge i_mclk);
    lnk_b.serial_shift_clock = 1'b1;
    repeat (8) @(negedge i_mclk);
    lnk_b.serial_shift_clock = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    logic [15:0] pats [4];
    logic [15:0] prev;
    int n;
    pats = '{16'ha5c3, 16'h8001, 16'h7ffe, 16'h0000};
    prev = 16'h0;
    lnk_b.serial_shift_clock = 1'b0;
    lnk_b.cs_n = 1'b1;
    lnk_b.rc_n = 1'b1;
    lnk_b.tag = 1'b0;
    lnk_b.clock_source_select = 1'b1;
    repeat (20) @(negedge i_mclk);
    check(lnk.clock_source_select, 1'b1);
    check({lnk.cs_n, lnk.rc_n, lnk.busy_n, lnk.data}, 4'he);
    check(o_valid, 1'b0);
    i_arst_n = 1'b1;
    // Back-to-back readouts, each returning the previous result
    for (int i = 0; i < 4; i++)
    begin
      frame(pats[i], i[0], prev);
      prev = pats[i];
    end
    $display("host frames done");
    // Second link: start, then arming cleared by source select low
    i_sample = 16'h3c5a;
    @(negedge i_mclk);
    lnk_b.cs_n = 1'b0;
    @(negedge i_mclk);
    lnk_b.rc_n = 1'b0;
    wait_on(2, 1'b0, n);
    check(n <= 16, 1'b1);
    pulse_b();
    lnk_b.rc_n = 1'b1;
    lnk_b.clock_source_select = 1'b0;
    repeat (4) @(negedge i_mclk);
    lnk_b.clock_source_select = 1'b1;
    pulse_b();
    // Give a wrongly armed sync time to land
    repeat (8) @(negedge i_mclk);
    check(lnk_b.data, 1'b0);
    // Arming with select high, then sync on pulse one
    lnk_b.cs_n = 1'b1;
    pulse_b();
    lnk_b.cs_n = 1'b0;
    pulse_b();
    // Sync lands some 13 cycles after the rise
    repeat (8) @(negedge i_mclk);
    check(lnk_b.data, 1'b1);
    // Convert again while converting is ignored
    lnk_b.rc_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    lnk_b.rc_n = 1'b1;
    wait_on(2, 1'b1, n);
    // A restarted conversion would keep busy low a full period more
    check(n < CONV - 40, 1'b1);
    check(conv_b, 1'b0);
    lnk_b.cs_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    check(res_b, 16'h3c5a);
    check(lnk_b.data, 1'b0);
    $display("second link done");
    stop_test();
  end
endmodule
`default_nettype wire
